//--- src/sciu_pkg.sv
// sciu_pkg: register map, field positions and reset values of the
// smartcard / uart interface. assumes a 32-bit apb with word offsets.
package sciu_pkg;
  // register byte offsets
  localparam logic [7:0] SCIU_OFS_FRAME = 8'h00;
  localparam logic [7:0] SCIU_OFS_PIN = 8'h04;
  localparam logic [7:0] SCIU_OFS_PROT = 8'h08;
  localparam logic [7:0] SCIU_OFS_IEN = 8'h10;
  localparam logic [7:0] SCIU_OFS_FLAG = 8'h14;
  localparam logic [7:0] SCIU_OFS_RDATA = 8'h18;
  localparam logic [7:0] SCIU_OFS_TDATA = 8'h1C;
  localparam logic [7:0] SCIU_OFS_BAUD = 8'h20;
  localparam logic [7:0] SCIU_OFS_BCMP = 8'h24;
  localparam logic [7:0] SCIU_OFS_RTO = 8'h28;
  localparam logic [7:0] SCIU_OFS_EGT = 8'h2C;
  localparam logic [7:0] SCIU_OFS_T3 = 8'h30;
  localparam logic [7:0] SCIU_OFS_T4 = 8'h34;
  // reset values
  localparam logic [31:0] SCIU_RST_ZERO = 32'h00000000;
  localparam logic [31:0] SCIU_RST_FLAG = 32'h00000004;
  localparam logic [31:0] SCIU_RST_BAUD = 32'h0000FFFF;
  localparam logic [31:0] SCIU_RST_RTO = 32'h0000FFFF;
  // frame_control fields
  localparam int SCIU_B_MODE = 15;
  localparam int SCIU_B_PEN = 14;
  localparam int SCIU_B_PTYPE = 13;
  localparam int SCIU_B_DLEN = 9;
  localparam int SCIU_B_STOP = 7;
  localparam int SCIU_B_OVRS = 4;
  localparam int SCIU_B_TXE = 3;
  localparam int SCIU_B_RXE = 2;
  localparam int SCIU_B_RTOEN = 1;
  localparam int SCIU_B_EN = 0;
  localparam logic [31:0] SCIU_MASK_FRAME = 32'h0000E69F;
  // card_pin_control fields
  localparam int SCIU_B_ACT = 15;
  localparam int SCIU_B_WARM = 14;
  localparam int SCIU_B_DEACT = 13;
  localparam int SCIU_B_INST = 9;
  localparam int SCIU_B_PWRLV = 8;
  localparam int SCIU_B_RSTLV = 7;
  localparam int SCIU_B_DATALV = 6;
  localparam int SCIU_B_CLKLV = 5;
  localparam int SCIU_B_CLKEN = 4;
  localparam logic [31:0] SCIU_MASK_PIN = 32'h0000E1FF;
  // flag_status fields
  localparam int SCIU_B_DOR = 15;
  localparam int SCIU_B_FE = 14;
  localparam int SCIU_B_PE = 13;
  localparam int SCIU_B_RXBUSY = 12;
  localparam int SCIU_B_RTOF = 6;
  localparam int SCIU_B_TXC = 2;
  localparam int SCIU_B_RXC = 0;
  // sample clocks per bit
  localparam logic [4:0] SCIU_OSR16 = 5'h10;
  localparam logic [4:0] SCIU_OSR8 = 5'h08;
endpackage

//--- src/sciu_top.sv
// sciu_top: smartcard interface with uart mode, apb register slave,
// frame engine, receive time-out and automatic card sequences.
// assumes pins from outside the pclk domain; card data is open-drain.
`timescale 1ns/1ns
module sciu_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // smartcard pins
  output logic card_power_out,
  output logic card_reset_out,
  output logic card_clock_out,
  input wire logic card_data_in,
  output logic card_data_out,
  output logic card_data_oe_n,
  input wire logic card_detect_in,
  // uart pins
  output logic uart_tx_out,
  input wire logic uart_rx_in
);
  import sciu_pkg::*;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    sciu_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    sciu_rx_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_WAIT_T3, SQ_WAIT_T4, SQ_WARM,
    SQ_DONE} sciu_seq_t;

  // registers
  logic [31:0] frame_ff, pin_ff, prot_ff, ien_ff, rdata_ff, tdata_ff;
  logic [31:0] baud_ff, bcmp_ff, rto_ff, egt_ff, t3_ff, t4_ff;
  logic [15:0] flag_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;

  // apb decode
  wire wr_en = psel & penable & pwrite & pready_ff;
  wire setup = psel & ~penable;
  wire a_frame = paddr == SCIU_OFS_FRAME;
  wire a_pin = paddr == SCIU_OFS_PIN;
  wire a_prot = paddr == SCIU_OFS_PROT;
  wire a_ien = paddr == SCIU_OFS_IEN;
  wire a_flag = paddr == SCIU_OFS_FLAG;
  wire a_rdata = paddr == SCIU_OFS_RDATA;
  wire a_tdata = paddr == SCIU_OFS_TDATA;
  wire a_baud = paddr == SCIU_OFS_BAUD;
  wire a_bcmp = paddr == SCIU_OFS_BCMP;
  wire a_rto = paddr == SCIU_OFS_RTO;
  wire a_egt = paddr == SCIU_OFS_EGT;
  wire a_t3 = paddr == SCIU_OFS_T3;
  wire a_t4 = paddr == SCIU_OFS_T4;
  wire a_hit = a_frame | a_pin | a_prot | a_ien | a_flag | a_rdata |
    a_tdata | a_baud | a_bcmp | a_rto | a_egt | a_t3 | a_t4;

  // configuration fields
  wire blk_en = frame_ff[SCIU_B_EN];
  wire uart_mode = frame_ff[SCIU_B_MODE];
  wire par_en = frame_ff[SCIU_B_PEN];
  wire par_even = frame_ff[SCIU_B_PTYPE];
  wire two_stop = frame_ff[SCIU_B_STOP];
  wire tx_on = blk_en & frame_ff[SCIU_B_TXE];
  wire rx_on = blk_en & frame_ff[SCIU_B_RXE];
  wire [3:0] nbits = {2'b00, frame_ff[SCIU_B_DLEN+1:SCIU_B_DLEN]} + 4'h5;
  wire [4:0] osr = frame_ff[SCIU_B_OVRS] ? SCIU_OSR8 : SCIU_OSR16;
  wire [4:0] osr_half = {1'b0, osr[4:1]};

  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] rxs_ff, dets_ff;
  logic rx_lvl_ff, det_lvl_ff;
  wire rx_pin = uart_mode ? uart_rx_in : card_data_in;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_ff <= 3'h7;
      dets_ff <= 3'h0;
      rx_lvl_ff <= 1'b1;
      det_lvl_ff <= 1'b0;
    end else begin
      rxs_ff <= {rxs_ff[1:0], rx_pin};
      dets_ff <= {dets_ff[1:0], card_detect_in};
      if (rxs_ff[1] == rxs_ff[2])
        rx_lvl_ff <= rxs_ff[2];
      if (dets_ff[1] == dets_ff[2])
        det_lvl_ff <= dets_ff[2];
    end
  end

  // sample clock divider: one tick every baud_divisor+1 pclks
  logic [15:0] bdiv_ff;
  logic samp_ff;
  logic [4:0] etu_cnt_ff;
  logic etu_ff;
  wire bdiv_wrap = bdiv_ff >= baud_ff[15:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdiv_ff <= 16'h0000;
      samp_ff <= 1'b0;
    end else begin
      bdiv_ff <= (bdiv_wrap | ~blk_en) ? 16'h0000 : bdiv_ff + 16'h0001;
      samp_ff <= bdiv_wrap & blk_en;
    end
  end

  // free-running baud unit for the time-out and card sequences
  wire etu_wrap = samp_ff & (etu_cnt_ff >= osr - 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      etu_cnt_ff <= 5'h00;
      etu_ff <= 1'b0;
    end else begin
      if (samp_ff)
        etu_cnt_ff <= etu_wrap ? 5'h00 : etu_cnt_ff + 5'h01;
      etu_ff <= etu_wrap;
    end
  end

  // transmitter
  sciu_tx_t tx_st_ff;
  logic [4:0] tx_ph_ff;
  logic [3:0] tx_idx_ff;
  logic [7:0] tx_sh_ff;
  logic tx_bit_ff, tx_par_ff, tx_stop2_ff;
  wire tx_start = wr_en & a_tdata & tx_on & (tx_st_ff == TX_IDLE);
  wire tx_bit_end = samp_ff & (tx_ph_ff == osr - 5'h01);
  wire tx_done = tx_bit_end & (tx_st_ff == TX_STOP) &
    ~(two_stop & ~tx_stop2_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff <= TX_IDLE;
      tx_ph_ff <= 5'h00;
      tx_idx_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      tx_bit_ff <= 1'b1;
      tx_par_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
    end else if (!tx_on) begin
      tx_st_ff <= TX_IDLE;
      tx_bit_ff <= 1'b1;
      tx_ph_ff <= 5'h00;
    end else if (tx_start) begin
      tx_st_ff <= TX_START;
      tx_bit_ff <= 1'b0;
      tx_ph_ff <= 5'h00;
      tx_sh_ff <= pwdata[7:0];
      tx_idx_ff <= 4'h0;
      tx_stop2_ff <= 1'b0;
      // odd parity makes the count of ones odd
      tx_par_ff <= ~par_even ^ (^(pwdata[7:0] &
        ~(8'hFF << nbits)));
    end else if (samp_ff && tx_st_ff != TX_IDLE) begin
      tx_ph_ff <= tx_bit_end ? 5'h00 : tx_ph_ff + 5'h01;
      if (tx_bit_end) begin
        unique case (tx_st_ff)
          TX_START, TX_DATA: begin
            if (tx_st_ff == TX_DATA && tx_idx_ff == nbits - 4'h1) begin
              tx_st_ff <= par_en ? TX_PAR : TX_STOP;
              tx_bit_ff <= par_en ? tx_par_ff : 1'b1;
            end else begin
              tx_st_ff <= TX_DATA;
              tx_bit_ff <= tx_sh_ff[0];
              tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
              if (tx_st_ff == TX_DATA)
                tx_idx_ff <= tx_idx_ff + 4'h1;
            end
          end
          TX_PAR: begin
            tx_st_ff <= TX_STOP;
            tx_bit_ff <= 1'b1;
          end
          TX_STOP: begin
            if (two_stop && !tx_stop2_ff)
              tx_stop2_ff <= 1'b1;
            else
              tx_st_ff <= TX_IDLE;
          end
          TX_IDLE: tx_st_ff <= TX_IDLE;
        endcase
      end
    end
  end

  // receiver
  sciu_rx_t rx_st_ff;
  logic [4:0] rx_ph_ff;
  logic [3:0] rx_idx_ff;
  logic [7:0] rx_sh_ff;
  logic rx_par_ff, rx_prev_ff;
  wire rx_fall = rx_prev_ff & ~rx_lvl_ff;
  wire rx_go = rx_on & (rx_st_ff == RX_IDLE) & rx_fall;
  wire rx_mid = samp_ff & (rx_ph_ff == osr_half);
  wire rx_wrap = samp_ff & (rx_ph_ff == osr - 5'h01);
  wire rx_last = rx_idx_ff == nbits - 4'h1;
  wire rx_end = rx_mid & (rx_st_ff == RX_STOP);
  wire par_bad = par_en & (rx_par_ff ^ ~par_even);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= RX_IDLE;
      rx_ph_ff <= 5'h00;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_lvl_ff;
      if (!rx_on) begin
        rx_st_ff <= RX_IDLE;
        rx_ph_ff <= 5'h00;
      end else if (rx_go) begin
        rx_st_ff <= RX_START;
        rx_ph_ff <= 5'h00;
        rx_idx_ff <= 4'h0;
        rx_sh_ff <= 8'h00;
        rx_par_ff <= 1'b0;
      end else if (samp_ff && rx_st_ff != RX_IDLE) begin
        rx_ph_ff <= rx_wrap ? 5'h00 : rx_ph_ff + 5'h01;
        if (rx_mid) begin
          rx_par_ff <= rx_par_ff ^ (rx_st_ff != RX_START && rx_lvl_ff);
          unique case (rx_st_ff)
            // a start that is high mid-bit was a glitch
            RX_START: rx_st_ff <= rx_lvl_ff ? RX_IDLE : RX_DATA;
            RX_DATA: begin
              rx_sh_ff[rx_idx_ff[2:0]] <= rx_lvl_ff;
              rx_idx_ff <= rx_idx_ff + 4'h1;
              if (rx_last)
                rx_st_ff <= par_en ? RX_PAR : RX_STOP;
            end
            RX_PAR: rx_st_ff <= RX_STOP;
            RX_STOP: rx_st_ff <= RX_IDLE;
            RX_IDLE: rx_st_ff <= RX_IDLE;
          endcase
        end
      end
    end
  end

  // receive time-out: reload at each start bit, count in baud units
  logic [15:0] rto_cnt_ff;
  logic rto_run_ff;
  wire rto_under = etu_ff & rto_run_ff & (rto_cnt_ff == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rto_cnt_ff <= 16'h0000;
      rto_run_ff <= 1'b0;
    end else if (!blk_en || !frame_ff[SCIU_B_RTOEN]) begin
      rto_run_ff <= 1'b0;
    end else if (rx_go) begin
      rto_cnt_ff <= rto_ff[15:0];
      rto_run_ff <= 1'b1;
    end else if (rto_under) begin
      rto_run_ff <= 1'b0;
    end else if (etu_ff && rto_run_ff) begin
      rto_cnt_ff <= rto_cnt_ff - 16'h0001;
    end
  end

  // automatic card sequences; activate timed in baud units by t3 then t4 registers, warm reset by t3 alone, deactivate untimed
  sciu_seq_t sq_ff;
  logic [15:0] sq_cnt_ff;
  wire sq_req = pin_ff[SCIU_B_ACT] | pin_ff[SCIU_B_WARM] |
    pin_ff[SCIU_B_DEACT];
  wire sq_exp = etu_ff & (sq_cnt_ff == 16'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_ff <= SQ_IDLE;
      sq_cnt_ff <= 16'h0000;
    end else if (!blk_en || uart_mode) begin
      sq_ff <= SQ_IDLE;
    end else begin
      if (etu_ff && sq_cnt_ff != 16'h0000)
        sq_cnt_ff <= sq_cnt_ff - 16'h0001;
      unique case (sq_ff)
        SQ_IDLE: if (sq_req) begin
          sq_cnt_ff <= t3_ff[15:0];
          sq_ff <= pin_ff[SCIU_B_DEACT] ? SQ_DONE :
            pin_ff[SCIU_B_WARM] ? SQ_WARM : SQ_WAIT_T3;
        end
        SQ_WAIT_T3: if (sq_exp) begin
          sq_cnt_ff <= t4_ff[15:0];
          sq_ff <= SQ_WAIT_T4;
        end
        SQ_WAIT_T4: if (sq_exp)
          sq_ff <= SQ_DONE;
        SQ_WARM: if (sq_exp)
          sq_ff <= SQ_DONE;
        SQ_DONE: sq_ff <= SQ_IDLE;
      endcase
    end
  end
  wire sq_fin = sq_ff == SQ_DONE;
  wire sq_act = pin_ff[SCIU_B_ACT];

  // card clock divider: half period of clkg pclks, at least one
  logic [3:0] cdiv_ff;
  logic cclk_ff;
  wire [3:0] cdiv_top = (pin_ff[3:0] == 4'h0) ? 4'h0 : pin_ff[3:0] - 4'h1;
  wire clk_run = pin_ff[SCIU_B_CLKEN] & ~uart_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdiv_ff <= 4'h0;
      cclk_ff <= 1'b0;
    end else if (!clk_run) begin
      cdiv_ff <= 4'h0;
      cclk_ff <= pin_ff[SCIU_B_CLKLV];
    end else begin
      cdiv_ff <= (cdiv_ff >= cdiv_top) ? 4'h0 : cdiv_ff + 4'h1;
      if (cdiv_ff >= cdiv_top)
        cclk_ff <= ~cclk_ff;
    end
  end

  // register writes; hardware updates of the pin levels during sequences
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ff <= SCIU_RST_ZERO;
      pin_ff <= SCIU_RST_ZERO;
      prot_ff <= SCIU_RST_ZERO;
      ien_ff <= SCIU_RST_ZERO;
      tdata_ff <= SCIU_RST_ZERO;
      baud_ff <= SCIU_RST_BAUD;
      bcmp_ff <= SCIU_RST_ZERO;
      rto_ff <= SCIU_RST_RTO;
      egt_ff <= SCIU_RST_ZERO;
      t3_ff <= SCIU_RST_ZERO;
      t4_ff <= SCIU_RST_ZERO;
    end else begin
      if (wr_en && a_frame) frame_ff <= pwdata & SCIU_MASK_FRAME;
      if (wr_en && a_prot) prot_ff <= pwdata;
      if (wr_en && a_ien) ien_ff <= pwdata;
      if (wr_en && a_tdata) tdata_ff <= {24'h000000, pwdata[7:0]};
      if (wr_en && a_baud) baud_ff <= {16'h0000, pwdata[15:0]};
      if (wr_en && a_bcmp) bcmp_ff <= pwdata;
      if (wr_en && a_rto) rto_ff <= {16'h0000, pwdata[15:0]};
      if (wr_en && a_egt) egt_ff <= pwdata;
      if (wr_en && a_t3) t3_ff <= pwdata;
      if (wr_en && a_t4) t4_ff <= pwdata;
      if (wr_en && a_pin)
        pin_ff <= pwdata & SCIU_MASK_PIN & ~(32'h1 << SCIU_B_INST);
      else if (sq_ff == SQ_IDLE && sq_req && sq_act)
        pin_ff[SCIU_B_PWRLV] <= 1'b1;
      else if (sq_ff == SQ_IDLE && sq_req) begin
        pin_ff[SCIU_B_RSTLV] <= 1'b0;
        if (pin_ff[SCIU_B_DEACT]) begin
          pin_ff[SCIU_B_CLKEN] <= 1'b0;
          pin_ff[SCIU_B_PWRLV] <= 1'b0;
        end
      end else if (sq_ff == SQ_WAIT_T3 && sq_exp) begin
        pin_ff[SCIU_B_CLKEN] <= 1'b1;
        pin_ff[SCIU_B_DATALV] <= 1'b1;
      end else if (sq_fin) begin
        if (!pin_ff[SCIU_B_DEACT])
          pin_ff[SCIU_B_RSTLV] <= 1'b1;
        pin_ff[SCIU_B_ACT] <= 1'b0;
        pin_ff[SCIU_B_WARM] <= 1'b0;
        pin_ff[SCIU_B_DEACT] <= 1'b0;
      end
    end
  end

  // status flags: hardware set wins over write-one clear
  logic [15:0] nxt_flag;
  wire [15:0] flag_clr = (wr_en & a_flag) ? pwdata[15:0] : 16'h0000;
  always_comb begin
    nxt_flag = flag_ff & ~flag_clr;
    if (tx_start) nxt_flag[SCIU_B_TXC] = 1'b0;
    if (tx_done) nxt_flag[SCIU_B_TXC] = 1'b1;
    if (rto_under) nxt_flag[SCIU_B_RTOF] = 1'b1;
    if (rx_end) begin
      nxt_flag[SCIU_B_RXC] = 1'b1;
      if (flag_ff[SCIU_B_RXC]) nxt_flag[SCIU_B_DOR] = 1'b1;
      if (!rx_lvl_ff) nxt_flag[SCIU_B_FE] = 1'b1;
      if (par_bad) nxt_flag[SCIU_B_PE] = 1'b1;
    end
    nxt_flag[SCIU_B_RXBUSY] = rx_st_ff != RX_IDLE;
    if (!blk_en) nxt_flag = SCIU_RST_FLAG[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= SCIU_RST_FLAG[15:0];
      rdata_ff <= SCIU_RST_ZERO;
    end else begin
      flag_ff <= nxt_flag;
      if (rx_end)
        rdata_ff <= {24'h000000, rx_sh_ff};
    end
  end

  // read mux; a data read leaves the receive flag set, it clears only by write-one or block disable
  wire [31:0] rd_mux = a_frame ? frame_ff :
    a_pin ? (pin_ff | ({31'h0, det_lvl_ff} << SCIU_B_INST)) :
    a_prot ? prot_ff : a_ien ? ien_ff :
    a_flag ? {16'h0000, flag_ff} : a_rdata ? rdata_ff :
    a_tdata ? tdata_ff : a_baud ? baud_ff : a_bcmp ? bcmp_ff :
    a_rto ? rto_ff : a_egt ? egt_ff : a_t3 ? t3_ff :
    a_t4 ? t4_ff : 32'h00000000;

  // apb answer: one wait-free access phase, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~a_hit;
      if (setup && !pwrite)
        prdata_ff <= rd_mux;
    end
  end

  // pin drivers from flops
  logic pwr_ff, rst_ff, dat_oe_n_ff, utx_ff;
  wire tx_low = (tx_st_ff != TX_IDLE) & ~tx_bit_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= 1'b0;
      rst_ff <= 1'b0;
      dat_oe_n_ff <= 1'b0;
      utx_ff <= 1'b1;
    end else begin
      pwr_ff <= ~uart_mode & pin_ff[SCIU_B_PWRLV];
      rst_ff <= ~uart_mode & pin_ff[SCIU_B_RSTLV];
      // open drain: pull low for a zero bit or a low level setting
      dat_oe_n_ff <= uart_mode | ~(tx_low | ~pin_ff[SCIU_B_DATALV]);
      utx_ff <= ~(uart_mode & tx_low);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign card_power_out = pwr_ff;
  assign card_reset_out = rst_ff;
  assign card_clock_out = cclk_ff;
  assign card_data_out = 1'b0;
  assign card_data_oe_n = dat_oe_n_ff;
  assign uart_tx_out = utx_ff;
endmodule

//--- testbench/sciu_asserts.sv
// sciu_asserts: bus and pin checks on the sciu_top ports.
// assumes one pclk domain with presetn as its reset; bound below.
`timescale 1ns/1ns
module sciu_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic card_power_out,
  input wire logic card_reset_out,
  input wire logic card_data_oe_n,
  input wire logic card_detect_in,
  input wire logic uart_tx_out
);
  import sciu_pkg::*;
  logic [31:0] frame_ff, pin_ff;
  logic seq_ff, det_lv_ff, wr_go, quiet;
  logic [1:0] quiet_ff;
  logic [2:0] det_ff;
  // shadows of written config; pins lag writes, so wait for quiet
  assign wr_go = psel && penable && pready && pwrite && !pslverr;
  assign quiet = quiet_ff == 2'h3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ff <= 32'h00000000;
      pin_ff <= 32'h00000000;
      seq_ff <= 1'h0;
      quiet_ff <= 2'h0;
    end else begin
      if (wr_go && paddr == SCIU_OFS_FRAME) frame_ff <= pwdata;
      if (wr_go && paddr == SCIU_OFS_PIN) pin_ff <= pwdata;
      if (wr_go && paddr == SCIU_OFS_PIN) seq_ff <= |pwdata[15:13];
      quiet_ff <= wr_go ? 2'h0 : (quiet ? quiet_ff : quiet_ff + 2'h1);
    end
  end
  // detect level counted stable, the status path has synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_lv_ff <= 1'h0;
      det_ff <= 3'h0;
    end else begin
      det_lv_ff <= card_detect_in;
      det_ff <= (card_detect_in != det_lv_ff) ? 3'h0 :
                (det_ff == 3'h7 ? det_ff : det_ff + 3'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_hole_refused: assert property
    (psel && !penable && paddr == 8'h0C |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_detect_shown: assert property (det_ff == 3'h7 && pready && !pwrite &&
    paddr == SCIU_OFS_PIN |-> prdata[SCIU_B_INST] == card_detect_in)
    else $error("detect status wrong");
  a_uart_pins_low: assert property (frame_ff[SCIU_B_MODE] && quiet
    |-> !card_power_out && !card_reset_out && card_data_oe_n)
    else $error("card pins active in uart mode");
  a_tx_line_idle: assert property (quiet && !(frame_ff[SCIU_B_TXE]
    && frame_ff[SCIU_B_EN]) |-> uart_tx_out [*4])
    else $error("tx line low while disabled");
  a_pin_levels: assert property (!frame_ff[SCIU_B_MODE] && !seq_ff
    && quiet |-> card_power_out == pin_ff[8] &&
    card_reset_out == pin_ff[7])
    else $error("pin level differs from control");
  c_tx_start: cover property ($fell(uart_tx_out));
  c_refused: cover property (pslverr);
  c_reset_up: cover property ($rose(card_reset_out));
endmodule
bind sciu_top sciu_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .card_power_out(card_power_out), .card_reset_out(card_reset_out),
  .card_data_oe_n(card_data_oe_n), .card_detect_in(card_detect_in),
  .uart_tx_out(uart_tx_out));

//--- testbench/sciu_uart_peer.sv
// sciu_uart_peer: far-end uart sender on the receive pin.
// assumes the link clock period is one bit time.
`timescale 1ns/1ns
module sciu_uart_peer (
  // timing
  input wire logic link_clk,
  // request from the bench
  input wire logic send,
  input wire logic [7:0] data_in,
  // line
  output logic rx_line
);
  logic [9:0] shift_ff;
  logic [3:0] left_ff;
  initial begin
    rx_line = 1'h1;
    left_ff = 4'h0;
  end
  // start, lsb first, stop; line rests high as with a pull-up
  always @(posedge link_clk) begin
    if (left_ff != 4'h0) begin
      rx_line <= shift_ff[0];
      shift_ff <= {1'h1, shift_ff[9:1]};
      left_ff <= left_ff - 4'h1;
    end else if (send) begin
      shift_ff <= {1'h1, data_in, 1'h0};
      left_ff <= 4'hA;
    end
  end
endmodule

//--- testbench/sciu_tb_top.sv
// sciu_tb_top: self-checking bench for sciu_top.
// assumes apb answers before the watchdog and baud_divisor 0
// (bit = osr pclks).
`timescale 1ns/1ns
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module sciu_tb_top;
  import sciu_pkg::*;
  typedef struct {
    logic [31:0] cfg;
    logic [7:0] d;
    logic [11:0] exp;
    int n;
  } sciu_row_t;
  // frame setup, byte, line bits first-out in bit 0 plus idle, count
  sciu_row_t rows [4] = '{'{32'h00008619, 8'h55, 12'h6AA, 11},
    '{32'h0000C099, 8'h13, 12'h3A6, 10},
    '{32'h0000E209, 8'h2A, 12'h3D4, 10},
    '{32'h00008499, 8'h7F, 12'h7FE, 11}};
  logic [1:0] seq_exp [3] = '{2'h3, 2'h3, 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, det = 1'h0, send = 1'h0, link_clk = 1'h0;
  logic [7:0] paddr = 8'h00, sbyte = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rv;
  logic pready, pslverr, ev, pwr, rst, sclk, dout, doe_n, txo, rxi, din;
  int fails = 0, samples_checked = 0, n;
  assign din = doe_n ? 1'h1 : dout; // open drain, pulled up
  always #50 pclk = ~pclk;
  // link timing runs at its own phase
  initial begin
    #130;
    forever #400 link_clk = ~link_clk;
  end
  sciu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_power_out(pwr), .card_reset_out(rst), .card_clock_out(sclk),
    .card_data_in(din), .card_data_out(dout), .card_data_oe_n(doe_n),
    .card_detect_in(det), .uart_tx_out(txo), .uart_rx_in(rxi));
  sciu_uart_peer u_peer (.link_clk(link_clk), .send(send),
    .data_in(sbyte), .rx_line(rxi));
  task automatic clk(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // one transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h00000000);
    `CHK(rv, e)
  endtask
  // request held longer than one link period so the peer sees it
  task automatic send_byte(input logic [7:0] b);
    sbyte <= b;
    send <= 1'h1;
    clk(12);
    send <= 1'h0;
    clk(100);
  endtask
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #3000000;
    fails++;
    complete_run();
  end
  initial begin
    clk(12);
    `CHK({pready, pslverr, pwr, rst, sclk, doe_n, txo}, 7'h01)
    presetn <= 1'h1;
    clk(1);
    rdchk(SCIU_OFS_FLAG, SCIU_RST_FLAG);
    // unmapped hole refused, reads zero
    rdchk(8'h0C, 32'h00000000);
    `CHK(ev, 1'h1)
    apb(1'h1, SCIU_OFS_BAUD, 32'h00000000);
    apb(1'h1, SCIU_OFS_T3, 32'h00000002);
    apb(1'h1, SCIU_OFS_T4, 32'h00000002);
    apb(1'h1, SCIU_OFS_FRAME, 32'h00000001);
    // each sequence bit clears itself; activate and warm reset leave power and reset high, deactivate leaves both low
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, SCIU_OFS_PIN, (32'h00008000 >> k) | 32'h00000100);
      rv = 32'h0000E000;
      n = 0;
      while (rv[15 - k] !== 1'h0 && n < 100) begin
        apb(1'h0, SCIU_OFS_PIN, 32'h00000000);
        n++;
      end
      `CHK(rv[15 - k], 1'h0)
      `CHK({pwr, rst}, seq_exp[k])
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, SCIU_OFS_PIN, 32'(i) << 7);
      clk(3);
      `CHK({pwr, rst}, 2'(i))
    end
    // card clock on, half period of three pclks
    apb(1'h1, SCIU_OFS_PIN, 32'h00000013);
    rv[0] = sclk;
    clk(3);
    `CHK(sclk, ~rv[0])
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008001);
    clk(3);
    `CHK({pwr, rst, doe_n}, 3'h1)
    // frame rows, sampled mid-bit; receiver left off while sending
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, SCIU_OFS_FRAME, rows[i].cfg);
      apb(1'h1, SCIU_OFS_TDATA, {24'h000000, rows[i].d});
      n = 0;
      while (txo !== 1'h0 && n < 40) begin
        clk(1);
        n++;
      end
      clk(rows[i].cfg[SCIU_B_OVRS] ? 3 : 7);
      for (int b = 0; b < rows[i].n; b++) begin
        `CHK(txo, rows[i].exp[b])
        clk(rows[i].cfg[SCIU_B_OVRS] ? 8 : 16);
      end
    end
    // two stops: complete flag only after the second stop ends
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008099);
    apb(1'h1, SCIU_OFS_TDATA, 32'h00000000);
    clk(57);
    apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
    `CHK(rv[SCIU_B_TXC], 1'h0)
    clk(5);
    apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
    `CHK(rv[SCIU_B_TXC], 1'h1)
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008011);
    apb(1'h1, SCIU_OFS_TDATA, 32'h00000000);
    for (int c = 0; c < 30; c++) begin
      clk(1);
      `CHK(txo, 1'h1)
    end
    apb(1'h1, SCIU_OFS_FLAG, 32'h0000FFFF);
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008615);
    send_byte(8'hA5);
    rdchk(SCIU_OFS_RDATA, 32'h000000A5);
    // peer stop bit is read as a parity one: odd passes, even fails
    for (int p = 0; p < 2; p++) begin
      apb(1'h1, SCIU_OFS_FLAG, 32'h0000FFFF);
      apb(1'h1, SCIU_OFS_FRAME, 32'h0000C615 | (32'(p) << 13));
      send_byte(8'hA5);
      apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
      `CHK(rv[SCIU_B_PE], 1'(p))
    end
    apb(1'h1, SCIU_OFS_FLAG, 32'h0000FFFF);
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008611);
    send_byte(8'h3C);
    apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
    `CHK(rv[SCIU_B_RXC], 1'h0)
    // time-out of 20 bit times from the start bit
    apb(1'h1, SCIU_OFS_RTO, 32'h00000014);
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008617);
    send_byte(8'h0F);
    apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
    `CHK(rv[SCIU_B_RTOF], 1'h0)
    clk(140);
    apb(1'h0, SCIU_OFS_FLAG, 32'h00000000);
    `CHK(rv[SCIU_B_RTOF], 1'h1)
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008613);
    apb(1'h1, SCIU_OFS_FRAME, 32'h00008612);
    rdchk(SCIU_OFS_FLAG, SCIU_RST_FLAG);
    rdchk(SCIU_OFS_FRAME, 32'h00008612);
    rdchk(SCIU_OFS_RTO, 32'h00000014);
    // detect pin level shown after the synchroniser settles
    for (int d = 1; d >= 0; d--) begin
      det <= 1'(d);
      clk(8);
      apb(1'h0, SCIU_OFS_PIN, 32'h00000000);
      `CHK(rv[SCIU_B_INST], 1'(d))
    end
    // short reset in mid-run restores register defaults
    presetn <= 1'h0;
    clk(2);
    presetn <= 1'h1;
    clk(1);
    rdchk(SCIU_OFS_RTO, SCIU_RST_RTO);
    complete_run();
  end
endmodule
